// ### pbp_pkg.sv
// package of constants and types for the picture bus port
package pbp_pkg;

  // ****************************************
  // clock and pixel rate
  // ****************************************
  localparam int CLK_RATE_KHZ = 40000;
  localparam int PIX_RATE_KHZ = 20250;
  localparam int PIX_STEP     = PIX_RATE_KHZ / 10;
  localparam int ACC_MOD      = CLK_RATE_KHZ / 10;
  localparam int ACC_W        = 13;

  // ****************************************
  // line and field timing, in pixels and lines
  // ****************************************
  localparam int LINE_PIXELS      = 1296;
  localparam int FIELD_LINES      = 312;
  localparam int MAIN_SYNC_WIDTH  = 95;
  localparam int FRONT_SYNC_WIDTH = 32;

  // ****************************************
  // data path sizes and values
  // ****************************************
  localparam int FIFO_DEPTH         = 8;
  localparam int MAP_ENTRIES        = 16;
  localparam logic [7:0] HALF_LEVEL = 8'h80;
  localparam logic [23:0] MAP_RESET = 24'h000000;
  localparam int RGB_R_BIT          = 0;
  localparam int RGB_G_BIT          = 1;
  localparam int RGB_B_BIT          = 2;
  localparam int IDX_BIT            = 0;
  localparam int MAP_EN_BIT         = 1;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
    logic [2:0] prio;
  } pbp_bus_t;

  typedef struct packed {
    logic [7:0]  luma;
    logic [7:0]  u;
    logic [7:0]  v;
    logic [2:0]  src;
    logic        rgb_ok;
    logic [23:0] rgb;
  } pbp_pix_t;

endpackage : pbp_pkg

// ### pbp_fifo.sv
// fifo of flip-flops with valid and ready on both sides
`timescale 1ns/10ps
module pbp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + (AW+1)'(1);
    end
  end

endmodule : pbp_fifo

// ### pbp_sync.sv
// line and field counter with main and front sync pulses
`timescale 1ns/10ps
module pbp_sync #(
  parameter int LINE_PIXELS      = pbp_pkg::LINE_PIXELS,
  parameter int FIELD_LINES      = pbp_pkg::FIELD_LINES,
  parameter int MAIN_SYNC_WIDTH  = pbp_pkg::MAIN_SYNC_WIDTH,
  parameter int FRONT_SYNC_WIDTH = pbp_pkg::FRONT_SYNC_WIDTH
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pix_en,
  output logic      line_first,
  output logic      line_last,
  output logic      field_start,
  output logic      main_sync,
  output logic      front_sync
);
  localparam int PW = $clog2(LINE_PIXELS);
  localparam int LW = $clog2(FIELD_LINES);

  logic [PW-1:0] pixel_q;
  logic [LW-1:0] line_q;
  logic          field_end;

  assign line_first = pixel_q == '0;
  assign line_last  = pixel_q == PW'(LINE_PIXELS - 1);
  assign field_end  = line_q == LW'(FIELD_LINES - 1);

  // ****************************************
  // counters
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pixel_q <= '0;
    end else if (pix_en) begin
      pixel_q <= line_last ? '0 : pixel_q + PW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      line_q <= '0;
    end else if (pix_en && line_last) begin
      line_q <= field_end ? '0 : line_q + LW'(1);
    end
  end

  // ****************************************
  // sync pulses
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      main_sync   <= 1'b0;
      front_sync  <= 1'b0;
      field_start <= 1'b0;
    end else begin
      field_start <= pix_en && line_last && field_end;
      if (pix_en) begin
        main_sync  <= line_last || (pixel_q < PW'(MAIN_SYNC_WIDTH - 1));
        front_sync <= (pixel_q >= PW'(LINE_PIXELS - FRONT_SYNC_WIDTH - 1)) && !line_last;
      end
    end
  end

  sequence s_line_wrap;
    pix_en && line_last;
  endsequence

  property p_msync;
    @(posedge clk) disable iff (rst)
    s_line_wrap |=> main_sync && !front_sync;
  endproperty
  a_msync: assert property (p_msync) else $error("main sync not raised at line start");

endmodule : pbp_sync

// ### pbp_port.sv
// picture bus port: bus drive, arbitration, uv demultiplex, rgb mode and colour map
//
// Overview of operation
// - luma lines carry one sample per tick of the 20.25 MHz pixel rate
// - in rgb mode luma bits 0,1,2 are single-bit red, green, blue
// - chroma lines carry u and v alternately, each at 10.125 MHz
// - the u/v multiplex restarts at every line start
// - in rgb mode chroma bits 0,1 are index bit and map-enable bit
// - map-enable 0 shows the rgb bits at half contrast
// - map-enable 1 selects one of 16 map entries by index,r,g,b
// - three priority lines select one of up to 8 sources
// - highest priority wins, decided afresh for every pixel
// - device drives main sync and front sync pulses for line timing
// - device outputs a one-cycle strobe per pixel tick on main clock out; bus timing derives from it
// - low on chip clear holds the whole port in reset
`timescale 1ns/10ps
module pbp_port (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              CHIP_CLEAR_N,
  input  wire pbp_pkg::pbp_bus_t BUS_I,
  output pbp_pkg::pbp_bus_t      BUS_O,
  output pbp_pkg::pbp_bus_t      BUS_OE,
  output logic                   MAIN_CLOCK_OUT,
  output logic                   MAIN_SYNC_PULSE,
  output logic                   FRONT_SYNC_PULSE,
  output logic                   FIELD_START,
  input  wire logic              RGB_MODE,
  input  wire logic              OWN_ENABLE,
  input  wire logic [2:0]        OWN_PRIORITY,
  input  wire logic [7:0]        OWN_LUMA,
  input  wire logic [7:0]        OWN_U,
  input  wire logic [7:0]        OWN_V,
  input  wire logic              MAP_WR,
  input  wire logic [3:0]        MAP_ADDR,
  input  wire logic [23:0]       MAP_DATA,
  output pbp_pkg::pbp_pix_t      PIX_OUT,
  output logic                   PIX_VALID,
  input  wire logic              PIX_READY,
  output logic                   FIFO_IN_READY,
  output logic                   OVERRUN
);
  import pbp_pkg::*;

  logic               clr;
  logic [ACC_W-1:0]   acc_q;
  logic [ACC_W-1:0]   acc_sum;
  logic               pix_en;
  logic               line_first;
  logic               line_last;
  pbp_bus_t           ext_q;
  logic               first_q;
  logic               cap_q;
  logic               rgb_q;
  logic               iph_q;
  logic               oph_q;
  logic               is_u;
  logic [7:0]         u_q;
  logic [7:0]         v_q;
  logic               win;
  logic [23:0]        map_q [MAP_ENTRIES];
  logic [3:0]         map_idx;
  logic               map_en;
  logic [23:0]        half_rgb;
  pbp_pix_t           word;

  // ****************************************
  // reset from either source
  // ****************************************
  assign clr = RST | ~CHIP_CLEAR_N;

  // ****************************************
  // pixel rate divider
  // ****************************************
  assign acc_sum = acc_q + ACC_W'(PIX_STEP);
  assign pix_en  = acc_sum >= ACC_W'(ACC_MOD);

  always_ff @(posedge CLK) begin
    if (clr) begin
      acc_q <= '0;
    end else begin
      acc_q <= pix_en ? acc_sum - ACC_W'(ACC_MOD) : acc_sum;
    end
  end

  always_ff @(posedge CLK) begin
    if (clr) begin
      MAIN_CLOCK_OUT <= 1'b0;
    end else begin
      MAIN_CLOCK_OUT <= pix_en;
    end
  end

  // ****************************************
  // line timing
  // ****************************************
  pbp_sync u_sync (
    .clk         (CLK),
    .rst         (clr),
    .pix_en      (pix_en),
    .line_first  (line_first),
    .line_last   (line_last),
    .field_start (FIELD_START),
    .main_sync   (MAIN_SYNC_PULSE),
    .front_sync  (FRONT_SYNC_PULSE)
  );

  // ****************************************
  // own source drive and arbitration
  // ****************************************
  assign win = OWN_ENABLE && (OWN_PRIORITY >= BUS_I.prio);

  always_ff @(posedge CLK) begin
    if (clr) begin
      BUS_O  <= '0;
      BUS_OE <= '0;
      oph_q  <= 1'b1;
    end else if (pix_en) begin
      BUS_OE      <= win ? '1 : '0;
      BUS_O.prio  <= OWN_PRIORITY;
      BUS_O.luma  <= OWN_LUMA;
      if (line_last) begin
        BUS_O.chroma <= OWN_U;
        oph_q        <= 1'b1;
      end else begin
        BUS_O.chroma <= oph_q ? OWN_V : OWN_U;
        oph_q        <= ~oph_q;
      end
    end
  end

  // ****************************************
  // bus capture
  // ****************************************
  always_ff @(posedge CLK) begin
    if (clr) begin
      ext_q   <= '0;
      first_q <= 1'b0;
      cap_q   <= 1'b0;
      rgb_q   <= 1'b0;
    end else begin
      cap_q <= pix_en;
      if (pix_en) begin
        ext_q   <= BUS_I;
        first_q <= line_first;
        rgb_q   <= RGB_MODE;
      end
    end
  end

  // ****************************************
  // uv demultiplex
  // ****************************************
  assign is_u = first_q | ~iph_q;

  always_ff @(posedge CLK) begin
    if (clr) begin
      iph_q <= 1'b0;
    end else if (cap_q) begin
      iph_q <= is_u;
    end
  end

  always_ff @(posedge CLK) begin
    if (clr) begin
      u_q <= '0;
      v_q <= '0;
    end else if (cap_q) begin
      if (is_u) begin
        u_q <= ext_q.chroma;
      end else begin
        v_q <= ext_q.chroma;
      end
    end
  end

  // ****************************************
  // colour map
  // ****************************************
  for (genvar i = 0; i < MAP_ENTRIES; i++) begin : g_map
    always_ff @(posedge CLK) begin
      if (clr) begin
        map_q[i] <= MAP_RESET;
      end else if (MAP_WR && (MAP_ADDR == 4'(i))) begin
        map_q[i] <= MAP_DATA;
      end
    end
  end

  // ****************************************
  // rgb mode decode
  // ****************************************
  assign map_en  = ext_q.chroma[MAP_EN_BIT];
  assign map_idx = {ext_q.chroma[IDX_BIT], ext_q.luma[RGB_R_BIT],
                    ext_q.luma[RGB_G_BIT], ext_q.luma[RGB_B_BIT]};
  assign half_rgb = {ext_q.luma[RGB_R_BIT] ? HALF_LEVEL : 8'h00,
                     ext_q.luma[RGB_G_BIT] ? HALF_LEVEL : 8'h00,
                     ext_q.luma[RGB_B_BIT] ? HALF_LEVEL : 8'h00};

  always_comb begin
    word.luma   = ext_q.luma;
    word.u      = is_u ? ext_q.chroma : u_q;
    word.v      = is_u ? v_q : ext_q.chroma;
    word.src    = ext_q.prio;
    word.rgb_ok = rgb_q;
    word.rgb    = 24'h000000;
    if (rgb_q) begin
      word.rgb = map_en ? map_q[map_idx] : half_rgb;
    end
  end

  // ****************************************
  // output fifo
  // ****************************************
  pbp_fifo #(
    .W     ($bits(pbp_pix_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst       (clr),
    .in_valid  (cap_q),
    .in_ready  (FIFO_IN_READY),
    .in_data   (word),
    .out_valid (PIX_VALID),
    .out_ready (PIX_READY),
    .out_data  (PIX_OUT)
  );

  always_ff @(posedge CLK) begin
    if (clr) begin
      OVERRUN <= 1'b0;
    end else if (cap_q && !FIFO_IN_READY) begin
      OVERRUN <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_gap;
    !pix_en ##1 pix_en;
  endsequence

  property p_pix_rate;
    @(posedge CLK) disable iff (clr)
    !pix_en |-> s_gap;
  endproperty
  a_pix_rate: assert property (p_pix_rate) else $error("pixel tick spacing wrong");

  property p_clk_out;
    @(posedge CLK) disable iff (clr)
    MAIN_CLOCK_OUT == $past(pix_en);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("main clock out not following tick");

  property p_uv_restart;
    @(posedge CLK) disable iff (clr)
    cap_q && first_q |=> iph_q && u_q == $past(ext_q.chroma);
  endproperty
  a_uv_restart: assert property (p_uv_restart) else $error("line did not start with u");

  property p_uv_alt;
    @(posedge CLK) disable iff (clr)
    cap_q && !first_q && iph_q |=> !iph_q && v_q == $past(ext_q.chroma);
  endproperty
  a_uv_alt: assert property (p_uv_alt) else $error("u and v not alternating");

  property p_half;
    @(posedge CLK) disable iff (clr)
    cap_q && rgb_q && !map_en && ext_q.luma[RGB_R_BIT] && FIFO_IN_READY && !PIX_VALID
      |=> PIX_VALID && PIX_OUT.rgb[23:16] == HALF_LEVEL;
  endproperty
  a_half: assert property (p_half) else $error("half contrast red wrong");

  property p_map;
    @(posedge CLK) disable iff (clr)
    MAP_WR |=> map_q[$past(MAP_ADDR)] == $past(MAP_DATA);
  endproperty
  a_map: assert property (p_map) else $error("colour map entry not written");

  property p_arb;
    @(posedge CLK) disable iff (clr)
    pix_en && OWN_ENABLE && (OWN_PRIORITY > BUS_I.prio)
      |=> BUS_OE.prio == 3'h7 && BUS_O.prio == $past(OWN_PRIORITY);
  endproperty
  a_arb: assert property (p_arb) else $error("winning source not driving");

  property p_lose;
    @(posedge CLK) disable iff (clr)
    pix_en && (!OWN_ENABLE || OWN_PRIORITY < BUS_I.prio) |=> BUS_OE == '0;
  endproperty
  a_lose: assert property (p_lose) else $error("losing source still driving");

  property p_clear;
    @(posedge CLK)
    !CHIP_CLEAR_N |=> BUS_OE == '0 && !PIX_VALID && !OVERRUN;
  endproperty
  a_clear: assert property (p_clear) else $error("chip clear did not clear port");

endmodule : pbp_port

// ### pbp_src.sv
// far-side picture source model driving the resolved picture bus
`timescale 1ns/10ps
module pbp_src (
  input  wire logic         clk,
  input  wire logic [1:0]   mode,
  output pbp_pkg::pbp_bus_t bus
);
  import pbp_pkg::*;
  int hold;
  initial begin
    bus = '1;
    hold = 0;
  end
  // released lines float up; mode 1 new sample each cycle, mode 2 slow
  always @(posedge clk) begin
    #2;
    hold = hold + 1;
    if (mode == 2'h0) begin
      bus = '1;
    end else if (mode == 2'h1 || hold % 4 == 0) begin
      bus = pbp_bus_t'(19'($urandom));
    end
  end
endmodule : pbp_src

// ### tb.sv
// self-checking bench for the picture bus port
`timescale 1ns/10ps
module tb;
  import pbp_pkg::*;
  logic        clk, rst, clr_n, rgb_mode, own_en, map_wr, pix_ready, rnd;
  logic [2:0]  own_prio;
  logic [7:0]  own_luma, own_u, own_v, ul, vl, xc;
  logic [3:0]  map_addr;
  logic [23:0] map_data;
  logic [1:0]  src_mode;
  pbp_bus_t    bus_i, bus_o, bus_oe;
  pbp_pix_t    pix_out, w;
  logic        mclk, msync, fsync, pix_valid, in_rdy, ovr_o;
  logic        tk, live, full, pend, ovr, xoe, fstart;
  logic [23:0] cmap [16];
  pbp_pix_t    q[$];
  int          error_cnt, tests_run, acc, pix, ms, fs, nt, rdy_pct, k;

  pbp_port u_pbp_port (.CLK(clk), .RST(rst), .CHIP_CLEAR_N(clr_n), .BUS_I(bus_i), .BUS_O(bus_o),
    .BUS_OE(bus_oe), .MAIN_CLOCK_OUT(mclk), .MAIN_SYNC_PULSE(msync), .FRONT_SYNC_PULSE(fsync),
    .FIELD_START(fstart), .RGB_MODE(rgb_mode), .OWN_ENABLE(own_en), .OWN_PRIORITY(own_prio),
    .OWN_LUMA(own_luma), .OWN_U(own_u), .OWN_V(own_v), .MAP_WR(map_wr), .MAP_ADDR(map_addr),
    .MAP_DATA(map_data), .PIX_OUT(pix_out), .PIX_VALID(pix_valid), .PIX_READY(pix_ready),
    .FIFO_IN_READY(in_rdy), .OVERRUN(ovr_o));
  pbp_src u_pbp_src (.clk(clk), .mode(src_mode), .bus(bus_i));

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  function automatic logic [23:0] rgbx(pbp_bus_t b, logic m);
    if (!m) return 24'h0;
    if (b.chroma[MAP_EN_BIT]) return cmap[{b.chroma[IDX_BIT], b.luma[RGB_R_BIT], b.luma[RGB_G_BIT], b.luma[RGB_B_BIT]}];
    return {b.luma[RGB_R_BIT] ? HALF_LEVEL : 8'h00, b.luma[RGB_G_BIT] ? HALF_LEVEL : 8'h00,
            b.luma[RGB_B_BIT] ? HALF_LEVEL : 8'h00};
  endfunction : rgbx

  // ****************************************
  // reference model
  // ****************************************
  always @(posedge clk) begin
    live = !(rst || !clr_n);
    tk = 0;
    if (!live) begin
      acc = 0;
      pix = 0;
      nt = 0;
      q.delete();
      pend = 0;
      ovr = 0;
      ul = 0;
      vl = 0;
      foreach (cmap[i]) cmap[i] = MAP_RESET;
    end else begin
      full = q.size() >= FIFO_DEPTH;
      if (pix_valid && pix_ready) begin
        if (q.size() == 0) chk(0, "pop from empty fifo");
        else chk(pix_out === q.pop_front(), "pixel word");
      end
      if (pend && !full) q.push_back(w);
      if (pend && full) ovr = 1;
      pend = 0;
      tk = acc + PIX_STEP >= ACC_MOD;
      acc = tk ? acc + PIX_STEP - ACC_MOD : acc + PIX_STEP;
      if (tk) begin
        if (pix % 2 == 0) ul = bus_i.chroma;
        else vl = bus_i.chroma;
        w = '{bus_i.luma, ul, vl, bus_i.prio, rgb_mode, rgbx(bus_i, rgb_mode)};
        pend = 1;
        xoe = own_en && own_prio >= bus_i.prio;
        xc = ((pix + 1) % LINE_PIXELS) % 2 == 0 ? own_u : own_v;
        if (nt >= 10 && nt < 10 + 2 * LINE_PIXELS) begin
          ms += msync;
          fs += fsync;
        end
        chk(!(msync && fsync), "sync overlap");
        nt++;
        pix = (pix + 1) % LINE_PIXELS;
      end
      if (map_wr) cmap[map_addr] = map_data;
    end
  end

  always @(posedge clk) begin
    #1;
    if (!live) begin
      chk(bus_oe === '0 && pix_valid === 1'b0 && in_rdy === 1'b1 && ovr_o === 1'b0, "reset state");
    end else begin
      chk(mclk === tk, "clock strobe");
      chk(pix_valid === (q.size() != 0) && in_rdy === (q.size() < FIFO_DEPTH), "fifo flags");
      chk(ovr_o === ovr, "overrun");
      chk(fstart === 1'b0, "field start before first field ended");
      if (tk) chk(bus_oe === pbp_bus_t'({19{xoe}}), "bus enable");
      if (tk && xoe) chk(bus_o.luma === own_luma && bus_o.prio === own_prio && bus_o.chroma === xc, "drive");
    end
  end

  always @(posedge clk) begin
    #2;
    if (rnd) begin
      own_en = $urandom % 4 != 0;
      own_prio = 3'($urandom);
      own_luma = 8'($urandom);
      own_u = 8'($urandom);
      own_v = 8'($urandom);
      pix_ready = ($urandom % 100) < rdy_pct;
    end
  end

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst, clr_n, rnd, rgb_mode, own_en, map_wr, pix_ready} = 7'b1100000;
    {own_prio, own_luma, own_u, own_v, map_addr, map_data} = '0;
    {src_mode, error_cnt, tests_run, ms, fs, rdy_pct} = '0;
    void'($urandom(59093));
    cyc(5);
    rst = 0;
    for (k = 0; k < MAP_ENTRIES; k++) begin
      {map_wr, map_addr, map_data} = {1'b1, 4'(k), 24'($urandom)};
      cyc(1);
    end
    map_wr = 0;
    {rnd, src_mode, rdy_pct} = {1'b1, 2'h1, 100};
    cyc(5400);
    chk(ms == 2 * MAIN_SYNC_WIDTH && fs == 2 * FRONT_SYNC_WIDTH, "sync widths");
    {rgb_mode, src_mode, rdy_pct} = {1'b1, 2'h2, 50};
    cyc(2000);
    rdy_pct = 0;
    for (k = 0; k < 60 && in_rdy !== 1'b0; k++) cyc(1);
    chk(in_rdy === 1'b0, "fifo fills");
    if (in_rdy !== 1'b0) report_and_stop();
    cyc(10);
    {rdy_pct, src_mode} = {100, 2'h0};
    for (k = 0; k < 60 && pix_valid !== 1'b0; k++) cyc(1);
    chk(pix_valid === 1'b0, "fifo drains");
    if (pix_valid !== 1'b0) report_and_stop();
    clr_n = 0;
    cyc(2);
    clr_n = 1;
    src_mode = 2'h1;
    cyc(400);
    report_and_stop();
  end
endmodule : tb
